//--- design/adcr_consts.svh
/*
 * Offsets, field positions, reset values and ramp defaults of the
 * amplifier control register bank. Included by bare name; definitions only.
 */
// Operation
// - The three-bit switching-frequency field picks 768, 384, 480 or 576 kHz, other codes are reserved, and it resets to 000.
// - The bridge-select bit picks ordinary bridge-tied load when clear and parallel bridge-tied load when set, resetting clear.
// - The two-bit modulation field picks BD, one-sided PWM or hybrid modulation, resets to 00, and code 11 is undefined.
// - The DSP-hold bit resets to 1 holding the DSP in reset, and clearing it lets the DSP start and send data.
// - Setting the mute bit ramps both channels smoothly down to silence and clearing it ramps them back up.
// - The two-bit power-state field selects deep sleep, sleep, high-impedance or play and resets to deep sleep.
// - With page wrap enabled and a non-zero book, an auto-increment past the page end continues at location 8 of the next page.
// - With page wrap disabled, an auto-increment past the page end wraps to location 0 of the same page.
// - The four-bit bit-clock ratio field records bit clocks per frame as 32, 64, 128, 256 or 512 times the sample rate.
// - The four-bit sample-rate field selects auto detection or a fixed rate, code 1011 is shared by 88.2 and 96 kHz, others reserved.
// - Writing 1 to the register-reset bit returns all control registers but page and book to their initial values and the bit clears itself.
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADCR_OFS_PAGE      8'h00
`define ADCR_OFS_RESET     8'h01
`define ADCR_OFS_STAGE     8'h02
`define ADCR_OFS_POWER     8'h03
`define ADCR_OFS_WRAP      8'h0F
`define ADCR_OFS_FRAME     8'h28
`define ADCR_OFS_BOOK      8'h7F

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define ADCR_RST_STAGE     8'h00
`define ADCR_RST_POWER     8'h10
`define ADCR_RST_WRAP      8'h00
`define ADCR_RST_FRAME     8'h00
`define ADCR_BIT_REGRESET  0
`define ADCR_BIT_PARALLEL_BRIDGED_LOAD      2
`define ADCR_BIT_DSPHOLD   4
`define ADCR_BIT_MUTE      3
`define ADCR_BIT_WRAPDIS   3
`define ADCR_PAGE_END      8'h7F
`define ADCR_PAGE_RESUME   8'h08

// ----------------------------------------------------------------------
// ramp defaults
// ----------------------------------------------------------------------
`define ADCR_GAIN_FULL     16'hFFFF
`define ADCR_RAMP_STEP     16'h0100

`endif

//--- design/adcr_pkg.sv
/*
 * Types of the amplifier control register bank.
 * Assumes nothing beyond the constants header.
 */
package adcr_pkg;

    // switching frequency codes
    typedef enum logic [2:0] {
        adcr_fsw_768k = 3'h0,
        adcr_fsw_384k = 3'h1,
        adcr_fsw_480k = 3'h3,
        adcr_fsw_576k = 3'h4
    } adcr_fsw_t;

    // modulation codes
    typedef enum logic [1:0] {
        adcr_mod_bd         = 2'h0,
        adcr_mod_one_sided_pwm = 2'h1,
        adcr_mod_hybrid     = 2'h2
    } adcr_mod_t;

    // device power states
    typedef enum logic [1:0] {
        adcr_pwr_deep_sleep = 2'h0,
        adcr_pwr_sleep      = 2'h1,
        adcr_pwr_hiz        = 2'h2,
        adcr_pwr_play       = 2'h3
    } adcr_pwr_t;

    // mute ramp state
    typedef enum logic [1:0] {
        adcr_ramp_idle,
        adcr_ramp_down,
        adcr_ramp_up
    } adcr_ramp_t;

endpackage : adcr_pkg

//--- design/adcr_mute_ramp.sv
/*
 * Soft mute gain ramp: one step per sample tick toward zero or full.
 * Assumes sample_tick is a one-cycle enable at the audio sample rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adcr_consts.svh"

module adcr_mute_ramp #(
    parameter logic [15:0] STEP = `ADCR_RAMP_STEP,
    parameter logic [15:0] FULL = `ADCR_GAIN_FULL
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // control
    input  wire logic        mute_req,
    input  wire logic        sample_tick,
    // result
    output logic      [15:0] gain,
    output logic             muted
);

    adcr_pkg::adcr_ramp_t state;
    adcr_pkg::adcr_ramp_t next_state;
    logic [15:0]          next_gain;
    wire  logic [16:0]    gain_up   = {1'b0, gain} + {1'b0, STEP};
    wire  logic           at_floor  = (gain <= STEP);
    wire  logic           at_top    = (gain_up >= {1'b0, FULL});

    // direction follows the request; a reversal mid ramp turns at once
    always_comb begin
        next_state = state;
        next_gain  = gain;
        case (state)
            adcr_pkg::adcr_ramp_idle: begin
                if (mute_req && gain != 16'h0000) begin
                    next_state = adcr_pkg::adcr_ramp_down;
                end else if (!mute_req && gain != FULL) begin
                    next_state = adcr_pkg::adcr_ramp_up;
                end
            end
            adcr_pkg::adcr_ramp_down: begin
                if (!mute_req) begin
                    next_state = adcr_pkg::adcr_ramp_up;
                end else if (sample_tick) begin
                    next_gain  = at_floor ? 16'h0000 : gain - STEP;
                    next_state = at_floor ? adcr_pkg::adcr_ramp_idle : state;
                end
            end
            adcr_pkg::adcr_ramp_up: begin
                if (mute_req) begin
                    next_state = adcr_pkg::adcr_ramp_down;
                end else if (sample_tick) begin
                    next_gain  = at_top ? FULL : gain_up[15:0];
                    next_state = at_top ? adcr_pkg::adcr_ramp_idle : state;
                end
            end
            default: next_state = adcr_pkg::adcr_ramp_idle;
        endcase
    end

    // gain starts at full so an unmuted device plays without a ramp
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= adcr_pkg::adcr_ramp_idle;
            gain  <= `ADCR_GAIN_FULL;
            muted <= 1'b0;
        end else begin
            state <= next_state;
            gain  <= next_gain;
            muted <= (next_gain == 16'h0000);
        end
    end

endmodule : adcr_mute_ramp
`default_nettype wire

//--- design/adcr_regs.sv
/*
 * Control register bank of a stereo class-D amplifier: output stage,
 * power state, soft mute, page wrap of the auto-incrementing register
 * pointer, and frame rate configuration.
 * Assumes a byte-wide control port already deserialised: a pointer
 * load strobe, and one-cycle read and write strobes at the pointer.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adcr_consts.svh"

module adcr_regs #(
    parameter logic [15:0] RAMP_STEP = `ADCR_RAMP_STEP
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // control port
    input  wire logic                      cp_addr_load,
    input  wire logic               [7:0]  cp_addr,
    input  wire logic                      cp_wr,
    input  wire logic               [7:0]  cp_wdata,
    input  wire logic                      cp_rd,
    output logic                    [7:0]  cp_rdata,
    output logic                    [7:0]  cp_pointer,
    output logic                    [7:0]  cp_page,
    output logic                    [7:0]  cp_book,
    // audio timing
    input  wire logic                      sample_tick,
    // output stage
    output adcr_pkg::adcr_fsw_t            switching_freq_select,
    output logic                           switching_freq_valid,
    output logic                           parallel_bridge_select,
    output adcr_pkg::adcr_mod_t            modulation_scheme,
    output logic                           modulation_valid,
    // power, dsp and mute
    output adcr_pkg::adcr_pwr_t            power_state,
    output logic                           dsp_hold_reset,
    output logic                    [15:0] mute_gain,
    output logic                           mute_done,
    // page wrap and frame rate
    output logic                           page_wrap_disable,
    output logic                    [3:0]  bitclock_per_frame,
    output logic                    [3:0]  sample_rate_select,
    output logic                           sample_rate_auto,
    output logic                           frame_config_valid
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] output_stage_config;
    logic [7:0] power_state_and_mute;
    logic [7:0] page_wrap_config;
    logic [7:0] frame_rate_config;

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    // the bank answers in book 0, page 0 only, except the page and book selects,
    // which answer everywhere; other reads outside it return zero from this block
    wire logic home      = (cp_book == 8'h00) && (cp_page == 8'h00);
    wire logic hit_page  = (cp_pointer == `ADCR_OFS_PAGE);
    wire logic hit_book  = (cp_pointer == `ADCR_OFS_BOOK);
    wire logic hit_rst   = home && (cp_pointer == `ADCR_OFS_RESET);
    wire logic hit_stage = home && (cp_pointer == `ADCR_OFS_STAGE);
    wire logic hit_power = home && (cp_pointer == `ADCR_OFS_POWER);
    wire logic hit_wrap  = home && (cp_pointer == `ADCR_OFS_WRAP);
    wire logic hit_frame = home && (cp_pointer == `ADCR_OFS_FRAME);
    wire logic reg_reset = cp_wr && hit_rst && cp_wdata[`ADCR_BIT_REGRESET];

    // ------------------------------------------------------------------
    // pointer auto increment
    // ------------------------------------------------------------------
    wire logic access    = cp_wr || cp_rd;
    wire logic at_end    = (cp_pointer == `ADCR_PAGE_END);
    wire logic to_next   = at_end && (cp_book != 8'h00)
                           && !page_wrap_config[`ADCR_BIT_WRAPDIS];
    // page writes take effect before the increment is applied; the increment sees the old book
    wire logic [7:0] eff_page = (cp_wr && hit_page) ? cp_wdata : cp_page;
    wire logic [7:0] next_page = to_next ? eff_page + 8'h01 : eff_page;
    wire logic [7:0] next_pointer =
        to_next ? `ADCR_PAGE_RESUME :
        at_end  ? 8'h00 :
                  cp_pointer + 8'h01;

    // pointer, page and book follow the port; a register reset leaves them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cp_pointer <= 8'h00;
            cp_page    <= 8'h00;
            cp_book    <= 8'h00;
        end else if (cp_addr_load) begin
            cp_pointer <= cp_addr;
        end else if (access) begin
            cp_pointer <= next_pointer;
            cp_page    <= next_page;
            if (cp_wr && hit_book) begin
                cp_book <= cp_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // the reset bit is never stored, so it reads back as zero at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_stage_config  <= `ADCR_RST_STAGE;
            power_state_and_mute <= `ADCR_RST_POWER;
            page_wrap_config     <= `ADCR_RST_WRAP;
            frame_rate_config    <= `ADCR_RST_FRAME;
        end else if (reg_reset) begin
            output_stage_config  <= `ADCR_RST_STAGE;
            power_state_and_mute <= `ADCR_RST_POWER;
            page_wrap_config     <= `ADCR_RST_WRAP;
            frame_rate_config    <= `ADCR_RST_FRAME;
        end else if (cp_wr) begin
            if (hit_stage) begin
                output_stage_config <= cp_wdata;
            end
            if (hit_power) begin
                power_state_and_mute <= cp_wdata;
            end
            if (hit_wrap) begin
                page_wrap_config <= cp_wdata;
            end
            if (hit_frame) begin
                frame_rate_config <= cp_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    wire logic [7:0] rd_mux =
        hit_page  ? cp_page :
        hit_book  ? cp_book :
        hit_stage ? output_stage_config :
        hit_power ? power_state_and_mute :
        hit_wrap  ? page_wrap_config :
        hit_frame ? frame_rate_config :
                    8'h00;

    // read data is captured on the read strobe and held until the next one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cp_rdata <= 8'h00;
        end else if (cp_rd) begin
            cp_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    wire logic [2:0] fsw_code = output_stage_config[6:4];
    wire logic [1:0] mod_code = output_stage_config[1:0];
    wire logic [3:0] bck_code = frame_rate_config[7:4];
    wire logic [3:0] fs_code  = frame_rate_config[3:0];

    // reserved switching codes are flagged, not remapped
    wire logic fsw_ok = (fsw_code == 3'h0) || (fsw_code == 3'h1)
                        || (fsw_code == 3'h3) || (fsw_code == 3'h4);
    // code 11 of modulation has no defined meaning
    wire logic mod_ok = (mod_code != 2'h3);
    wire logic bck_ok = (bck_code == 4'h3) || (bck_code == 4'h5)
                        || (bck_code == 4'h7) || (bck_code == 4'h9)
                        || (bck_code == 4'hB);
    // 1011 stands for both 88.2 and 96 kHz; the rate must come from elsewhere
    wire logic fs_ok  = (fs_code == 4'h0) || (fs_code == 4'h2)
                        || (fs_code == 4'h4) || (fs_code == 4'h6)
                        || (fs_code == 4'h8) || (fs_code == 4'h9)
                        || (fs_code == 4'hB);
    // an unset ratio of zero is accepted so the reset state is not an error
    wire logic frame_ok = (bck_ok || bck_code == 4'h0) && fs_ok;

    // outputs are registered so the power stage never sees a decode glitch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            switching_freq_select  <= adcr_pkg::adcr_fsw_768k;
            switching_freq_valid   <= 1'b1;
            parallel_bridge_select <= 1'b0;
            modulation_scheme      <= adcr_pkg::adcr_mod_bd;
            modulation_valid       <= 1'b1;
            power_state            <= adcr_pkg::adcr_pwr_deep_sleep;
            dsp_hold_reset         <= 1'b1;
            page_wrap_disable      <= 1'b0;
            bitclock_per_frame     <= 4'h0;
            sample_rate_select     <= 4'h0;
            sample_rate_auto       <= 1'b1;
            frame_config_valid     <= 1'b1;
        end else begin
            switching_freq_select  <= adcr_pkg::adcr_fsw_t'(fsw_code);
            switching_freq_valid   <= fsw_ok;
            parallel_bridge_select <= output_stage_config[`ADCR_BIT_PARALLEL_BRIDGED_LOAD];
            modulation_scheme      <= adcr_pkg::adcr_mod_t'(mod_code);
            modulation_valid       <= mod_ok;
            power_state <= adcr_pkg::adcr_pwr_t'(power_state_and_mute[1:0]);
            // the host waits for its clocks to settle before clearing this
            dsp_hold_reset <= power_state_and_mute[`ADCR_BIT_DSPHOLD];
            page_wrap_disable      <= page_wrap_config[`ADCR_BIT_WRAPDIS];
            bitclock_per_frame     <= bck_code;
            sample_rate_select     <= fs_code;
            sample_rate_auto       <= (fs_code == 4'h0);
            frame_config_valid     <= frame_ok;
        end
    end

    // ------------------------------------------------------------------
    // soft mute
    // ------------------------------------------------------------------
    adcr_mute_ramp #(
        .STEP        (RAMP_STEP),
        .FULL        (`ADCR_GAIN_FULL)
    ) u_ramp (
        .clk         (clk),
        .reset_n     (reset_n),
        .mute_req    (power_state_and_mute[`ADCR_BIT_MUTE]),
        .sample_tick (sample_tick),
        .gain        (mute_gain),
        .muted       (mute_done)
    );

endmodule : adcr_regs
`default_nettype wire

//--- sim/adcr_regs_assertions.sv
/* checker of the amplifier control bank: field decode, ramp and pointer.
   assumes binding into adcr_regs, with its RAMP_STEP handed on. */
`timescale 1ns/100ps
`default_nettype none
module adcr_regs_assertions #(
    parameter logic [15:0] RAMP_STEP = 16'h0100
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset_n,
    // control port
    input wire logic                 cp_addr_load,
    input wire logic                 cp_wr,
    input wire logic                 cp_rd,
    input wire logic [7:0]           cp_wdata,
    input wire logic [7:0]           cp_pointer,
    input wire logic [7:0]           cp_page,
    input wire logic [7:0]           cp_book,
    input wire logic                 sample_tick,
    // decoded fields
    input wire adcr_pkg::adcr_fsw_t  switching_freq_select,
    input wire logic                 switching_freq_valid,
    input wire logic                 parallel_bridge_select,
    input wire adcr_pkg::adcr_mod_t  modulation_scheme,
    input wire logic                 modulation_valid,
    input wire adcr_pkg::adcr_pwr_t  power_state,
    input wire logic                 dsp_hold_reset,
    input wire logic [15:0]          mute_gain,
    input wire logic                 mute_done,
    input wire logic                 page_wrap_disable,
    input wire logic [3:0]           bitclock_per_frame,
    input wire logic [3:0]           sample_rate_select,
    input wire logic                 sample_rate_auto
);
    // accesses that store: only book 0 page 0; a store in a load strobe cycle still lands but is not checked
    wire logic home     = !cp_addr_load && cp_page == 8'h00 && cp_book == 8'h00;
    wire logic wr_stage = home && cp_wr && cp_pointer == 8'h02;
    wire logic wr_power = home && cp_wr && cp_pointer == 8'h03;
    wire logic wr_frame = home && cp_wr && cp_pointer == 8'h28;
    wire logic wr_clear = home && cp_wr && cp_pointer == 8'h01 && cp_wdata[0];
    wire logic rd_end   = !cp_addr_load && cp_rd && !cp_wr && cp_pointer == 8'h7F;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // field decode: register edge, then one more for the decode
    // ----------------------------------------------------------------
    a_fsw_write: assert property (wr_stage && !$past(wr_clear) |-> ##2
        switching_freq_select == $past(cp_wdata[6:4], 2)) else $error("fsw not written");
    a_fsw_valid: assert property (switching_freq_valid ==
        (switching_freq_select inside {3'h0, 3'h1, 3'h3, 3'h4})) else $error("fsw valid wrong");
    a_bridge_write: assert property (wr_stage && !$past(wr_clear) |-> ##2
        parallel_bridge_select == $past(cp_wdata[2], 2)) else $error("bridge not written");
    a_mod_valid: assert property (modulation_valid ==
        (modulation_scheme != 2'h3)) else $error("modulation valid wrong");
    a_power_write: assert property (wr_power |-> ##2 (dsp_hold_reset ==
        $past(cp_wdata[4], 2) && power_state == $past(cp_wdata[1:0], 2)))
        else $error("power field not written");
    a_frame_write: assert property (wr_frame |-> ##2
        bitclock_per_frame == $past(cp_wdata[7:4], 2)) else $error("ratio not written");
    a_rate_auto: assert property (sample_rate_auto ==
        (sample_rate_select == 4'h0)) else $error("auto rate flag wrong");
    a_reg_clear: assert property (wr_clear |-> ##3
        (power_state == 2'h0 && dsp_hold_reset)) else $error("register reset missed");
    // ----------------------------------------------------------------
    // mute ramp: moves only on a tick and never by more than one step
    // ----------------------------------------------------------------
    a_mute_done: assert property (mute_done == (mute_gain == 16'h0000))
        else $error("mute done flag wrong");
    a_gain_step: assert property ($changed(mute_gain) |-> $past(sample_tick) &&
        ((mute_gain > $past(mute_gain)) ? mute_gain - $past(mute_gain)
        : $past(mute_gain) - mute_gain) <= RAMP_STEP) else $error("gain step wrong");
    // ----------------------------------------------------------------
    // pointer at the page end
    // ----------------------------------------------------------------
    a_wrap_same: assert property (rd_end && page_wrap_disable |=>
        cp_pointer == 8'h00 && cp_page == $past(cp_page)) else $error("same page wrap wrong");
    a_wrap_next: assert property (rd_end && !page_wrap_disable && cp_book != 8'h00 |=>
        cp_pointer == 8'h08 && cp_page == $past(cp_page) + 8'h01) else $error("next page wrong");

    c_clear: cover property (wr_clear);
    c_next:  cover property (rd_end && !page_wrap_disable && cp_book != 8'h00);
    c_muted: cover property ($rose(mute_done));
endmodule : adcr_regs_assertions

bind adcr_regs adcr_regs_assertions #(.RAMP_STEP(RAMP_STEP)) u_chk (
    .clk(clk), .reset_n(reset_n), .cp_addr_load(cp_addr_load), .cp_wr(cp_wr),
    .cp_rd(cp_rd), .cp_wdata(cp_wdata), .cp_pointer(cp_pointer), .cp_page(cp_page),
    .cp_book(cp_book), .sample_tick(sample_tick),
    .switching_freq_select(switching_freq_select), .switching_freq_valid(switching_freq_valid),
    .parallel_bridge_select(parallel_bridge_select), .modulation_scheme(modulation_scheme),
    .modulation_valid(modulation_valid), .power_state(power_state),
    .dsp_hold_reset(dsp_hold_reset), .mute_gain(mute_gain), .mute_done(mute_done),
    .page_wrap_disable(page_wrap_disable), .bitclock_per_frame(bitclock_per_frame),
    .sample_rate_select(sample_rate_select), .sample_rate_auto(sample_rate_auto));
`default_nettype wire

//--- sim/adcr_host.sv
/* host model: drives the byte-wide control port with one-cycle strobes.
   assumes tasks are called by the bench; strobes change at falling edges. */
`timescale 1ns/100ps
`default_nettype none
module adcr_host (
    // clock
    input  wire logic       clk,
    // control port
    output var  logic       cp_addr_load,
    output var  logic [7:0] cp_addr,
    output var  logic       cp_wr,
    output var  logic [7:0] cp_wdata,
    output var  logic       cp_rd
);
    // idle port; a released data byte shows its inverse, never the old value
    initial begin
        cp_addr_load = 1'b0;
        cp_addr      = 8'h00;
        cp_wr        = 1'b0;
        cp_wdata     = 8'h00;
        cp_rd        = 1'b0;
    end
    // each strobe lasts one cycle, with an idle cycle before the next
    task automatic ld(input logic [7:0] a);
        @(negedge clk) begin cp_addr_load = 1'b1; cp_addr = a; end
        @(negedge clk) begin cp_addr_load = 1'b0; cp_addr = ~a; end
    endtask : ld
    task automatic wr(input logic [7:0] d);
        @(negedge clk) begin cp_wr = 1'b1; cp_wdata = d; end
        @(negedge clk) begin cp_wr = 1'b0; cp_wdata = ~d; end
    endtask : wr
    task automatic rd();
        @(negedge clk) cp_rd = 1'b1;
        @(negedge clk) cp_rd = 1'b0;
    endtask : rd
endmodule : adcr_host
`default_nettype wire

//--- sim/testbench.sv
/* self-checking bench of the amplifier control register bank.
   assumes the host model and the bound checker; fast ramp step. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0, reset_n = 1'b0, tick = 1'b0, pend = 1'b0;
    logic cp_addr_load, cp_wr, cp_rd;
    logic [7:0] cp_addr, cp_wdata, rdata, ptr, page, book, d, r, p;
    logic [15:0] gain;
    logic fsw_ok, parallel_bridged_load, mod_ok, dsp, done, wrapdis, auto, fcv;
    logic [3:0] bpf, rate;
    adcr_pkg::adcr_fsw_t fsw;
    adcr_pkg::adcr_mod_t modu;
    adcr_pkg::adcr_pwr_t pwr;
    logic [7:0] exp_q[$];
    int err_count = 0, checked = 0, seed, k;
    always #50 clk = ~clk;
    adcr_host u_host (.clk(clk), .cp_addr_load(cp_addr_load), .cp_addr(cp_addr),
        .cp_wr(cp_wr), .cp_wdata(cp_wdata), .cp_rd(cp_rd));
    adcr_regs #(.RAMP_STEP(16'h4000)) u_dut (.clk(clk), .reset_n(reset_n),
        .cp_addr_load(cp_addr_load), .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata),
        .cp_rd(cp_rd), .cp_rdata(rdata), .cp_pointer(ptr), .cp_page(page), .cp_book(book),
        .sample_tick(tick), .switching_freq_select(fsw), .switching_freq_valid(fsw_ok),
        .parallel_bridge_select(parallel_bridged_load), .modulation_scheme(modu), .modulation_valid(mod_ok),
        .power_state(pwr), .dsp_hold_reset(dsp), .mute_gain(gain), .mute_done(done),
        .page_wrap_disable(wrapdis), .bitclock_per_frame(bpf), .sample_rate_select(rate),
        .sample_rate_auto(auto), .frame_config_valid(fcv));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        u_host.ld(a);
        u_host.wr(v);
    endtask : wreg
    // note the expectation queued before the read strobe
    task automatic rdat(input logic [7:0] a, input logic [7:0] e);
        u_host.ld(a);
        exp_q.push_back(e);
        u_host.rd();
    endtask : rdat
    task automatic ticks_until(input logic [15:0] g);
        for (k = 0; k < 24 && gain !== g; k++) begin
            @(negedge clk) tick = 1'b1;
            @(negedge clk) tick = 1'b0;
        end
    endtask : ticks_until
    // monitor: read data settles a cycle after the strobe
    always @(posedge clk) pend <= cp_rd;
    always @(negedge clk) if (pend) chk(rdata, exp_q.pop_front());
    // watchdog: the run needs under 3000 cycles
    initial begin
        #(20000 * 100);
        err_count++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h001b;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        chk(dsp, 1'b1);
        chk(pwr, 2'h0);
        rdat(8'h02, 8'h00);
        rdat(8'h03, 8'h10);
        rdat(8'h0F, 8'h00);
        rdat(8'h28, 8'h00);
        rdat(8'h05, 8'h00);
        // every fsw and modulation code, random filler
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            d = {r[7], i[2:0], r[3:2], i[1:0]};
            wreg(8'h02, d);
            rdat(8'h02, d);
            chk(fsw, i[2:0]);
            chk(fsw_ok, i inside {0, 1, 3, 4});
            chk(parallel_bridged_load, d[2]);
            chk(mod_ok, i[1:0] != 2'h3);
            chk(modu, i[1:0]);
        end
        // decode lags a cycle; no audio clocks here
        for (int i = 0; i < 4; i++) begin
            wreg(8'h03, {3'h0, i[0], 2'h0, i[1:0]});
            @(negedge clk);
            chk(pwr, i[1:0]);
            chk(dsp, i[0]);
        end
        for (int i = 0; i < 16; i++) begin
            d = {i[3:0], 4'hF - i[3:0]};
            wreg(8'h28, d);
            rdat(8'h28, d);
            chk(bpf, d[7:4]);
            chk(auto, d[3:0] == 4'h0);
            chk(rate, d[3:0]);
            chk(fcv, d[7:4] inside {0, 3, 5, 7, 9, 11} && d[3:0] inside {0, 2, 4, 6, 8, 9, 11});
        end
        // soft mute down to zero, then up a step at a time
        wreg(8'h03, 8'h0B);
        ticks_until(16'h0000);
        chk(done, 1'b1);
        wreg(8'h03, 8'h03);
        for (k = 0; k < 8 && gain === 16'h0000; k++) begin
            @(negedge clk) tick = 1'b1;
            @(negedge clk) tick = 1'b0;
        end
        chk(gain, 16'h4000);
        ticks_until(16'hFFFF);
        chk(gain, 16'hFFFF);
        wreg(8'h01, 8'h01);
        rdat(8'h03, 8'h10);
        rdat(8'h01, 8'h00);
        // page end: wrap disabled stays, enabled moves on
        wreg(8'h0F, 8'h08);
        wreg(8'h7F, 8'h01);
        rdat(8'h7F, 8'h01);
        chk(ptr, 8'h00);
        chk(page, 8'h00);
        rdat(8'h02, 8'h00);
        wreg(8'h7F, 8'h00);
        wreg(8'h0F, 8'h00);
        wreg(8'h7F, 8'h01);
        p = page;
        rdat(8'h7F, 8'h01);
        chk(ptr, 8'h08);
        chk(page, p + 8'h01);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
